// ===== logic/omc_defines.svh
// Timing counts, field positions and encodings for the operating-mode controller.
// Assumes a 125 MHz core clock; included by the package and the design modules.
`ifndef OMC_DEFINES_SVH
`define OMC_DEFINES_SVH

`define OMC_CLK_PERIOD_NS 8
`define OMC_RESET_DWELL_NS 400
`define OMC_RESET_DWELL_CYC (`OMC_RESET_DWELL_NS / `OMC_CLK_PERIOD_NS)
`define OMC_SLEEP_ENTRY_CYC_DEF 1024
`define OMC_WAKE_HOLD_CYC_DEF 256
`define OMC_AUTO_RESTART_CYC_DEF 8192
`define OMC_UNLOCK_BIT 1
`define OMC_RUN_EN_BIT 2
`define OMC_SLEEP_BIT 3
`define OMC_MAP1_HI 15
`define OMC_MAP1_LO 14
`define OMC_MAP2_HI 13
`define OMC_MAP2_LO 12
`define OMC_FERR_BIT 27
`define OMC_MAP_OFF 2'h0
`define OMC_MAP_PWM 2'h1
`define OMC_MAP_ON 2'h2
`define OMC_MAP_DIN 2'h3
`define OMC_MAP1_DEF 2'h3
`define OMC_MAP2_DEF 2'h0

`endif

// ===== logic/omc_hold_timer.sv
// Counts how long a condition has held without a break.
// Assumes cond_in is synchronous to clk_in.
`include "omc_defines.svh"
module omc_hold_timer #(
	parameter int unsigned LIMIT = 16
) (
	// Clock and control
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Condition
	input wire logic cond_in,
	output logic done_out
);
	logic [31:0] cnt_reg;
	wire at_limit = (cnt_reg >= LIMIT);

	// Any break in the condition restarts the count
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= 32'h0;
		end else if (ce_in) begin
			if (!cond_in)
				cnt_reg <= 32'h0;
			else if (!at_limit)
				cnt_reg <= cnt_reg + 32'h1;
		end
	end
	assign done_out = at_limit;
endmodule

// ===== logic/omc_mode_ctrl.sv
// Operating-mode controller: sleep, pre-sleep, reset, limp home and active.
// Assumes a serial frame decoder on ref_clk_in supplying one-cycle frame strobes;
// pins chip_select_low and direct input come from outside and are synchronised here.
`include "omc_defines.svh"
module omc_mode_ctrl
	import omc_pkg::*;
#(
	parameter int unsigned SLEEP_ENTRY_CYC = `OMC_SLEEP_ENTRY_CYC_DEF,
	parameter int unsigned WAKE_HOLD_CYC = `OMC_WAKE_HOLD_CYC_DEF,
	parameter int unsigned AUTO_RESTART_CYC = `OMC_AUTO_RESTART_CYC_DEF
) (
	// Clock, reset, enable
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	// Pins from the host
	input wire logic chip_select_low_in,
	input wire logic direct_in,
	// Frames from the serial decoder
	input wire logic frame_valid_in,
	input wire omc_frame_t frame_in,
	// Monitors and sources
	input wire logic spi_supply_uv_in,
	input wire logic watchdog_timer_fail_in,
	input wire logic pwm_gen_in,
	input wire logic ferr_event_in,
	// Mode and drive
	output omc_mode_t mode_out,
	output omc_drive_t drive_out,
	output logic logic_supply_on_out,
	output logic spi_active_out,
	output logic regs_default_out,
	output logic functional_error_flag_out,
	output logic [1:0] map1_out,
	output logic [1:0] map2_out
);
	localparam int unsigned RST_DWELL = (`OMC_RESET_DWELL_CYC < 1) ? 1 : `OMC_RESET_DWELL_CYC;

	// ==========================================================
	// Reset release and pin synchronisers
	logic [1:0] rst_sync_reg;
	logic [1:0] csl_sync_reg;
	logic [1:0] din_sync_reg;
	wire rst_n = rst_sync_reg[1];

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	// Chip select idles high, so resets to inactive level
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			csl_sync_reg <= 2'h3;
			din_sync_reg <= 2'h0;
		end else if (clk_en_in) begin
			csl_sync_reg <= {csl_sync_reg[0], chip_select_low_in};
			din_sync_reg <= {din_sync_reg[0], direct_in};
		end
	end
	wire csl_s = csl_sync_reg[1];
	wire din_s = din_sync_reg[1];

	// ==========================================================
	// Hold timers
	omc_mode_t mode_reg, mode_next;
	wire in_sleep = (mode_reg == OMC_SLEEP);
	wire in_pre = (mode_reg == OMC_PRESLEEP);
	wire in_rst = (mode_reg == OMC_RESET);
	wire in_limp = (mode_reg == OMC_LIMP);
	wire in_act = (mode_reg == OMC_ACTIVE);
	wire idle_cond = csl_s && !din_s;
	wire wake_cond = din_s || !csl_s;
	wire sleep_done;
	wire wake_done;

	omc_hold_timer #(
		.LIMIT(SLEEP_ENTRY_CYC)
	) u_sleep_timer (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n),
		.ce_in(clk_en_in),
		.cond_in(idle_cond && in_pre),
		.done_out(sleep_done)
	);

	omc_hold_timer #(
		.LIMIT(WAKE_HOLD_CYC)
	) u_wake_timer (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n),
		.ce_in(clk_en_in),
		.cond_in(wake_cond && in_sleep),
		.done_out(wake_done)
	);

	// ==========================================================
	// Frame decode
	logic unlock_reg;
	// Only frames while the serial port is active count
	wire frame_ok = frame_valid_in && (in_pre || in_limp || in_act);
	wire cmd_sleep = frame_in.go_to_sleep && !frame_in.run_en;
	wire cmd_run = frame_in.run_en && !frame_in.go_to_sleep;
	wire cmd_both0 = !frame_in.run_en && !frame_in.go_to_sleep;
	wire cmd_both1 = frame_in.run_en && frame_in.go_to_sleep;
	wire unlocked_frame = frame_ok && unlock_reg;

	// Unlock armed by a frame, consumed or dropped by the next one
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n)
			unlock_reg <= 1'b0;
		else if (clk_en_in) begin
			if (in_rst || in_sleep)
				unlock_reg <= 1'b0;
			else if (frame_ok)
				unlock_reg <= frame_in.unlock;
		end
	end

	// ==========================================================
	// Mode state machine
	logic [8:0] dwell_reg;

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			OMC_SLEEP: begin
				if (wake_done)
					mode_next = OMC_RESET;
			end
			OMC_PRESLEEP: begin
				if (sleep_done)
					mode_next = OMC_SLEEP;
			end
			OMC_RESET: begin
				if (dwell_reg >= 9'(RST_DWELL - 1))
					mode_next = OMC_LIMP;
			end
			OMC_LIMP: begin
				if (unlocked_frame && cmd_sleep)
					mode_next = OMC_PRESLEEP;
				else if (unlocked_frame && cmd_run)
					mode_next = OMC_ACTIVE;
			end
			OMC_ACTIVE: begin
				if (spi_supply_uv_in || watchdog_timer_fail_in)
					mode_next = OMC_RESET;
				else if (frame_ok && cmd_both0)
					mode_next = OMC_RESET;
				else if (unlocked_frame && cmd_both1)
					mode_next = OMC_RESET;
				else if (unlocked_frame && cmd_sleep)
					mode_next = OMC_PRESLEEP;
			end
			default: mode_next = OMC_RESET;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n)
			mode_reg <= OMC_SLEEP;
		else if (clk_en_in)
			mode_reg <= mode_next;
	end

	// Reset dwell counter
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n)
			dwell_reg <= 9'h0;
		else if (clk_en_in)
			dwell_reg <= in_rst ? dwell_reg + 9'h1 : 9'h0;
	end

	// ==========================================================
	// Mapping fields
	logic [1:0] map1_reg;
	logic [1:0] map2_reg;

	// Writes in limp home are accepted and dropped
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			map1_reg <= `OMC_MAP1_DEF;
			map2_reg <= `OMC_MAP2_DEF;
		end else if (clk_en_in) begin
			if (in_rst || in_sleep) begin
				map1_reg <= `OMC_MAP1_DEF;
				map2_reg <= `OMC_MAP2_DEF;
			end else if (frame_ok && frame_in.map_wr && !in_limp) begin
				map1_reg <= frame_in.map1;
				map2_reg <= frame_in.map2;
			end
		end
	end

	function automatic logic map_drive(input logic [1:0] m, input logic pwm, input logic din);
		case (m)
			`OMC_MAP_OFF: map_drive = 1'b0;
			`OMC_MAP_PWM: map_drive = pwm;
			`OMC_MAP_ON: map_drive = 1'b1;
			default: map_drive = din;
		endcase
	endfunction

	// ==========================================================
	// Functional error flag and auto restart
	logic ferr_reg;
	logic [31:0] restart_reg;
	wire restart_tick = in_limp && (restart_reg >= AUTO_RESTART_CYC - 1);

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n)
			restart_reg <= 32'h0;
		else if (clk_en_in)
			restart_reg <= (!in_limp || restart_tick) ? 32'h0 : restart_reg + 32'h1;
	end

	// A new event in the tick cycle wins over the clear
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n)
			ferr_reg <= 1'b0;
		else if (clk_en_in) begin
			if (ferr_event_in && !in_rst && !in_sleep)
				ferr_reg <= 1'b1;
			else if (restart_tick || in_rst || in_sleep)
				ferr_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Registered outputs
	wire drv1 = in_act ? map_drive(map1_reg, pwm_gen_in, din_s) : (in_limp && din_s);
	wire drv2 = in_act ? map_drive(map2_reg, pwm_gen_in, din_s) : 1'b0;

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mode_out <= OMC_SLEEP;
			drive_out <= '0;
			logic_supply_on_out <= 1'b0;
			spi_active_out <= 1'b0;
			regs_default_out <= 1'b0;
			functional_error_flag_out <= 1'b0;
			map1_out <= `OMC_MAP1_DEF;
			map2_out <= `OMC_MAP2_DEF;
		end else if (clk_en_in) begin
			mode_out <= mode_reg;
			drive_out <= '{ch1: drv1, ch2: drv2};
			logic_supply_on_out <= !in_sleep;
			spi_active_out <= in_pre || in_limp || in_act;
			regs_default_out <= in_rst;
			functional_error_flag_out <= ferr_reg;
			map1_out <= map1_reg;
			map2_out <= map2_reg;
		end
	end
endmodule

// ===== logic/omc_pkg.sv
// Types for the operating-mode controller.
// Assumes omc_defines.svh is on the include path.
`include "omc_defines.svh"
package omc_pkg;
	typedef enum logic [4:0] {
		OMC_SLEEP = 5'h01,
		OMC_PRESLEEP = 5'h02,
		OMC_RESET = 5'h04,
		OMC_LIMP = 5'h08,
		OMC_ACTIVE = 5'h10
	} omc_mode_t;

	// One accepted serial write frame
	typedef struct packed {
		logic unlock;
		logic run_en;
		logic go_to_sleep;
		logic map_wr;
		logic [1:0] map1;
		logic [1:0] map2;
	} omc_frame_t;

	// Channel drive outputs
	typedef struct packed {
		logic ch1;
		logic ch2;
	} omc_drive_t;
endpackage

// ===== tb/omc_host_model.sv
// Host model: wake pins and decoded write frames.
// Assumes the bench calls its tasks; drives after falling edges.
module omc_host_model
	import omc_pkg::*;
(
	// Clock
	input wire logic ref_clk_in,
	// Pins and frames
	output logic chip_select_low_out,
	output logic direct_out,
	output logic frame_valid_out,
	output omc_frame_t frame_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		chip_select_low_out = 1'b1;
		direct_out = 1'b0;
		frame_valid_out = 1'b0;
		frame_out = '0;
	end
	// =========
	// Frames; data inverted once released, never left holding
	task automatic send(input omc_frame_t f);
		@(negedge ref_clk_in);
		frame_out = f;
		frame_valid_out = 1'b1;
		@(negedge ref_clk_in);
		frame_valid_out = 1'b0;
		frame_out = ~f;
	endtask
	task automatic unlock_mode(input logic run, input logic slp);
		send(8'hC0);
		send({1'b0, run, slp, 5'h00});
	endtask
	task automatic pins(input logic cs_n, input logic din);
		@(negedge ref_clk_in);
		chip_select_low_out = cs_n;
		direct_out = din;
	endtask
endmodule

// ===== tb/omc_mode_ctrl_properties.sv
// Port assertions for the mode controller.
// Assumes one core clock and the bind below.
module omc_mode_ctrl_properties
	import omc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Inputs watched
	input wire logic frame_valid_in,
	input wire omc_frame_t frame_in,
	input wire logic spi_supply_uv_in,
	input wire logic watchdog_timer_fail_in,
	// Outputs watched
	input wire omc_mode_t mode_out,
	input wire omc_drive_t drive_out,
	input wire logic logic_supply_on_out,
	input wire logic spi_active_out,
	input wire logic regs_default_out,
	input wire logic [1:0] map1_out,
	input wire logic [1:0] map2_out
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);
	// =========
	// Mode checks
	reset_dwell_a: assert property ($rose(mode_out == OMC_RESET) |->
		##49 mode_out == OMC_RESET ##1 mode_out == OMC_LIMP) else $error("reset dwell");
	sleep_exit_a: assert property (mode_out != OMC_SLEEP &&
		$past(mode_out) == OMC_SLEEP |-> mode_out == OMC_RESET) else $error("wake path");
	sleep_outs_a: assert property (mode_out == OMC_SLEEP |->
		!logic_supply_on_out && !spi_active_out) else $error("sleep outputs");
	presleep_outs_a: assert property (mode_out == OMC_PRESLEEP &&
		$past(mode_out) == OMC_PRESLEEP |-> drive_out == 2'h0 && logic_supply_on_out
		&& spi_active_out) else $error("presleep outputs");
	reset_outs_a: assert property (mode_out == OMC_RESET &&
		$past(mode_out) == OMC_RESET |-> regs_default_out && !spi_active_out
		&& map1_out == 2'h3 && map2_out == 2'h0) else $error("reset outputs");
	limp_outs_a: assert property (mode_out == OMC_LIMP &&
		$past(mode_out) == OMC_LIMP |-> !drive_out.ch2 && spi_active_out
		&& map1_out == 2'h3 && map2_out == 2'h0) else $error("limp outputs");
	frame_reset_a: assert property (mode_out == OMC_ACTIVE && frame_valid_in &&
		!frame_in.unlock && !frame_in.run_en && !frame_in.go_to_sleep
		|-> ##[1:2] mode_out == OMC_RESET) else $error("frame reset");
	fault_reset_a: assert property (mode_out == OMC_ACTIVE &&
		(spi_supply_uv_in || watchdog_timer_fail_in) |-> ##[1:2] mode_out == OMC_RESET)
		else $error("fault reset");
endmodule

bind omc_mode_ctrl omc_mode_ctrl_properties u_props (.ref_clk_in, .nrst_in,
	.frame_valid_in, .frame_in, .spi_supply_uv_in, .watchdog_timer_fail_in, .mode_out,
	.drive_out, .logic_supply_on_out, .spi_active_out, .regs_default_out, .map1_out,
	.map2_out);

// ===== tb/tb_top.sv
// Bench: wake, reset dwell, frame sequences and channel mapping.
// Assumes short test counts passed to the controller.
`include "omc_defines.svh"
module tb_top
	import omc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, uv, wd, pwm, ferr, cs_low, din, fv, sup, spi, flag, ce, rdef;
	logic [1:0] m1, m2;
	omc_frame_t fr;
	omc_mode_t mode;
	omc_drive_t drv;
	int failures, cmp_count, n;
	omc_mode_ctrl #(.SLEEP_ENTRY_CYC(8), .WAKE_HOLD_CYC(4), .AUTO_RESTART_CYC(16))
	u_omc_mode_ctrl (.ref_clk_in(clk), .nrst_in(nrst), .clk_en_in(ce),
		.chip_select_low_in(cs_low), .direct_in(din), .frame_valid_in(fv), .frame_in(fr),
		.spi_supply_uv_in(uv), .watchdog_timer_fail_in(wd), .pwm_gen_in(pwm),
		.ferr_event_in(ferr), .mode_out(mode), .drive_out(drv), .logic_supply_on_out(sup),
		.spi_active_out(spi), .regs_default_out(rdef), .functional_error_flag_out(flag),
		.map1_out(m1), .map2_out(m2));
	omc_host_model u_omc_host_model (.ref_clk_in(clk), .chip_select_low_out(cs_low),
		.direct_out(din), .frame_valid_out(fv), .frame_out(fr));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// =========
	// Helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("failures=%0d comparisons=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_mode(input omc_mode_t m, input int lim);
		int i = 0;
		while (mode !== m && i < lim) begin
			@(negedge clk);
			i++;
		end
		check(mode, m);
		if (mode !== m)
			test_done();
	endtask
	function automatic logic exp_ch(input logic [1:0] code, input logic p, input logic d);
		case (code)
			2'h0: return 1'b0;
			2'h1: return p;
			2'h2: return 1'b1;
			default: return d;
		endcase
	endfunction
	// =========
	// Sequence
	initial begin
		{nrst, uv, wd, pwm, ferr} = '0;
		ce = 1'b1;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		check({mode, sup}, 6'h02);
		u_omc_host_model.pins(1'b1, 1'b1);
		u_omc_host_model.pins(1'b1, 1'b0);
		repeat (10) @(negedge clk);
		check(mode, OMC_SLEEP);
		u_omc_host_model.pins(1'b1, 1'b1);
		wait_mode(OMC_RESET, 20);
		n = 0;
		while (mode === OMC_RESET && n < 60) begin
			@(negedge clk);
			n++;
		end
		check(16'(n), 16'(`OMC_RESET_DWELL_CYC));
		repeat (2) @(negedge clk);
		check({mode, drv, m1, m2}, {OMC_LIMP, 6'h2C});
		// Writes in limp home change nothing; a broken unlock is lost
		u_omc_host_model.send(8'h1A);
		u_omc_host_model.send(8'hC0);
		u_omc_host_model.send(8'h19);
		u_omc_host_model.send(8'h40);
		repeat (4) @(negedge clk);
		check({mode, m1, m2}, {OMC_LIMP, 4'hC});
		ferr = 1'b1;
		@(negedge clk);
		ferr = 1'b0;
		repeat (2) @(negedge clk);
		check(flag, 1'b1);
		n = 0;
		while (flag === 1'b1 && n < 24) begin
			@(negedge clk);
			n++;
		end
		check(flag, 1'b0);
		u_omc_host_model.unlock_mode(1'b1, 1'b0);
		wait_mode(OMC_ACTIVE, 8);
		for (int c = 3; c >= 0; c--) begin
			u_omc_host_model.send({4'h5, 2'(c), ~2'(c)});
			for (int p = 0; p < 4; p++) begin
				pwm = p[0];
				u_omc_host_model.pins(1'b1, p[1]);
				repeat (4) @(negedge clk);
				check({m1, drv}, {2'(c), exp_ch(2'(c), p[0], p[1]),
					exp_ch(~2'(c), p[0], p[1])});
			end
		end
		u_omc_host_model.send(8'h00);
		wait_mode(OMC_RESET, 6);
		check(rdef, 1'b1);
		wait_mode(OMC_LIMP, 60);
		check({m1, m2}, 4'hC);
		// Frozen core must ignore a whole activation sequence
		ce = 1'b0;
		u_omc_host_model.unlock_mode(1'b1, 1'b0);
		repeat (2) @(negedge clk);
		check(mode, OMC_LIMP);
		ce = 1'b1;
		// Supply fault, watchdog, then the unlocked reset frame
		for (int k = 0; k < 3; k++) begin
			u_omc_host_model.unlock_mode(1'b1, 1'b0);
			wait_mode(OMC_ACTIVE, 8);
			if (k == 2)
				u_omc_host_model.unlock_mode(1'b1, 1'b1);
			uv = (k == 0);
			wd = (k == 1);
			wait_mode(OMC_RESET, 8);
			{uv, wd} = 2'h0;
			wait_mode(OMC_LIMP, 60);
		end
		u_omc_host_model.unlock_mode(1'b0, 1'b1);
		wait_mode(OMC_PRESLEEP, 8);
		repeat (2) @(negedge clk);
		check({drv, sup, spi}, 4'h3);
		u_omc_host_model.pins(1'b1, 1'b0);
		repeat (5) @(negedge clk);
		u_omc_host_model.pins(1'b0, 1'b0);
		u_omc_host_model.pins(1'b1, 1'b0);
		repeat (6) @(negedge clk);
		check(mode, OMC_PRESLEEP);
		wait_mode(OMC_SLEEP, 20);
		u_omc_host_model.pins(1'b0, 1'b0);
		wait_mode(OMC_RESET, 20);
		// Pre-sleep reached from active as well
		wait_mode(OMC_LIMP, 60);
		u_omc_host_model.unlock_mode(1'b1, 1'b0);
		wait_mode(OMC_ACTIVE, 8);
		u_omc_host_model.unlock_mode(1'b0, 1'b1);
		wait_mode(OMC_PRESLEEP, 8);
		test_done();
	end
endmodule
